/* rtl/sipm_pkg.sv */
// Package for the sleep and idle power manager: register map, fields, states and carriers.
// Assumes a 32-bit Avalon-MM register port and one 200 MHz core clock.
package sipm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and fields
    localparam logic [1:0] SIPM_CTRL_ADDR = 2'h0;
    localparam logic [1:0] SIPM_STATUS_ADDR = 2'h1;
    localparam int SIPM_IDLE_EN_BIT = 0;
    localparam int SIPM_SCS_LSB = 1;
    localparam int SIPM_TWO_SPEED_BIT = 3;
    localparam int SIPM_FSCM_BIT = 4;
    localparam int SIPM_WDT_SEL_BIT = 5;
    localparam int SIPM_SEC_EN_BIT = 6;
    localparam int SIPM_CTRL_W = 7;
    localparam logic [SIPM_CTRL_W-1:0] SIPM_CTRL_RESET = 7'h00;
    localparam logic [31:0] SIPM_ZERO_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Clock source select encodings
    localparam logic [1:0] SIPM_SRC_PRI = 2'h0;
    localparam logic [1:0] SIPM_SRC_SEC = 2'h1;
    localparam logic [1:0] SIPM_SRC_INT = 2'h2;

    // Default CPU start delay in core clock cycles
    localparam int SIPM_START_DELAY_DEF = 8;
    localparam int SIPM_DLY_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Mode states, one-hot
    typedef enum logic [4:0] {
        SIPM_ST_RUN = 5'b00001,
        SIPM_ST_SLEEP = 5'b00010,
        SIPM_ST_IDLE = 5'b00100,
        SIPM_ST_WAKE_WAIT = 5'b01000,
        SIPM_ST_START_DLY = 5'b10000
    } sipm_state_t;

    // Software controls
    typedef struct packed {
        logic sec_osc_en;
        logic wdt_sel;
        logic fscm_en;
        logic two_speed_en;
        logic [1:0] system_clock_select;
        logic idle_on_sleep_enable;
    } sipm_ctrl_t;

    // Oscillator ready inputs: internal, secondary, primary
    typedef struct packed {
        logic internal_rc_source;
        logic sec;
        logic pri;
    } sipm_rdy_t;

    // Clock gating and oscillator enables toward the clock tree
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic [1:0] sys_clk_sel;
        logic pri_osc_en;
        logic sec_osc_en;
        logic internal_rc_source_en;
    } sipm_clk_t;

endpackage : sipm_pkg

/* rtl/sipm_power_manager.sv */
// Sleep and idle power manager: mode FSM, clock gating, oscillator keep-alive, start delay.
// Assumes CPU core and wake sources on core_clk_in; oscillator ready pins are asynchronous.
//
// Functional notes
// - Sleep instruction with idle enable clear enters Sleep, clears clock status flags.
// - In Sleep/Idle, internal RC runs if watchdog selected; secondary runs if enabled.
// - After Sleep wake with two-speed and fail-safe off, no clocks until the selected source is ready.
// - Two-speed or fail-safe enabled: wake from Sleep runs on internal oscillator.
// - Primary clock status flag set once primary clock drives the device; code sets it only on a Run-mode switch or Sleep wake onto primary.
// - Wake never alters idle enable or system clock select bits.
// - Sleep instruction with idle enable set stops CPU unless secondary is selected but not enabled; peripherals keep selected clock.
// - Idle entry leaves clock status flags unchanged.
// - Idle exits only on interrupt, watchdog time-out or reset.
// - After Idle wake, CPU waits the start delay before executing.
// - CPU resumes on the same clock source used during Idle.
// - Watchdog wake goes to the Run mode the clock select bits choose.
// - Primary idle keeps primary clock running; no warm-up on wake.
// - Primary idle clocks peripherals from primary source; status flag stays set.
// - Primary idle wake clocks CPU from primary after the start delay.
// - Status flag stays set across primary idle wake.
`timescale 1ns/1ps
module sipm_power_manager
    import sipm_pkg::*;
#(
    parameter int START_DELAY_CYCLES = SIPM_START_DELAY_DEF
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // Avalon-MM slave
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // CPU core and wake sources
    input wire logic sleep_instr_in,
    input wire logic irq_wake_in,
    input wire logic watchdog_timer_timeout_in,
    input wire logic [3:0] oscillator_config_bits_in,
    // Oscillator ready pins
    input wire sipm_rdy_t osc_rdy_in,
    // Clock tree controls and status
    output sipm_clk_t clk_ctl_out,
    output logic primary_clock_status_flag_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        sipm_state_t st;
        sipm_ctrl_t ctrl;
        logic [1:0] act_src;
        logic flag;
        logic [SIPM_DLY_W-1:0] dly_cnt;
        sipm_rdy_t rdy_s1;
        sipm_rdy_t rdy_s2;
        logic ack;
        logic [31:0] rdata;
    } sipm_regs_t;

    localparam logic [SIPM_DLY_W-1:0] DLY_LOAD = SIPM_DLY_W'(START_DELAY_CYCLES - 1);

    sipm_regs_t state_reg;
    sipm_regs_t state_next;
    logic bus_req;
    logic bus_done;
    logic wr_ctrl;
    logic sel_rdy;
    logic wake_ev;

    assign bus_req = avs_read_in | avs_write_in;
    assign bus_done = bus_req & state_reg.ack & ce_in;
    assign avs_waitrequest_out = bus_req & ~bus_done;
    assign avs_readdata_out = state_reg.rdata;
    assign wr_ctrl = avs_write_in & bus_done & (avs_address_in == SIPM_CTRL_ADDR);
    assign wake_ev = irq_wake_in | watchdog_timer_timeout_in;

    // Readiness of the source named by the clock select bits
    always_comb begin
        case (state_reg.ctrl.system_clock_select)
            SIPM_SRC_PRI: sel_rdy = state_reg.rdy_s2.pri;
            SIPM_SRC_SEC: sel_rdy = state_reg.rdy_s2.sec;
            default: sel_rdy = state_reg.rdy_s2.internal_rc_source;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.rdy_s1 = osc_rdy_in;
        state_next.rdy_s2 = state_reg.rdy_s1;
        // Register port: one wait cycle, then answer
        state_next.ack = bus_req & ~state_reg.ack;
        if (bus_req & ~state_reg.ack) begin
            case (avs_address_in)
                SIPM_CTRL_ADDR: state_next.rdata = {25'h000_0000, state_reg.ctrl};
                SIPM_STATUS_ADDR: state_next.rdata = {16'h0000, oscillator_config_bits_in, 1'b0,
                    state_reg.rdy_s2, state_reg.flag, state_reg.act_src, state_reg.st};
                default: state_next.rdata = SIPM_ZERO_WORD;
            endcase
        end
        if (wr_ctrl) begin
            state_next.ctrl = avs_writedata_in[SIPM_CTRL_W-1:0];
        end
        case (state_reg.st)
            SIPM_ST_RUN: begin
                if (sleep_instr_in & ~state_reg.ctrl.idle_on_sleep_enable) begin
                    state_next.st = SIPM_ST_SLEEP;
                    state_next.flag = 1'b0;
                end else if (sleep_instr_in & ~(state_reg.ctrl.system_clock_select == SIPM_SRC_SEC
                        & ~state_reg.ctrl.sec_osc_en)) begin
                    // Idle keeps flags; peripherals move to the selected source
                    state_next.st = SIPM_ST_IDLE;
                    state_next.act_src = state_reg.ctrl.system_clock_select;
                end else if (state_reg.act_src != state_reg.ctrl.system_clock_select & sel_rdy) begin
                    state_next.act_src = state_reg.ctrl.system_clock_select;
                    state_next.flag = (state_reg.ctrl.system_clock_select == SIPM_SRC_PRI);
                end
            end
            SIPM_ST_SLEEP: begin
                // Forget stale ready flags so the wake waits for a fresh one
                state_next.rdy_s1 = '0;
                state_next.rdy_s2 = '0;
                if (wake_ev) begin
                    state_next.st = SIPM_ST_WAKE_WAIT;
                end
            end
            SIPM_ST_IDLE: begin
                if (wake_ev) begin
                    state_next.st = SIPM_ST_START_DLY;
                    state_next.dly_cnt = DLY_LOAD;
                end
            end
            SIPM_ST_WAKE_WAIT: begin
                if (state_reg.ctrl.two_speed_en | state_reg.ctrl.fscm_en) begin
                    state_next.act_src = SIPM_SRC_INT;
                    state_next.st = SIPM_ST_START_DLY;
                    state_next.dly_cnt = DLY_LOAD;
                end else if (sel_rdy) begin
                    state_next.act_src = state_reg.ctrl.system_clock_select;
                    state_next.flag = (state_reg.ctrl.system_clock_select == SIPM_SRC_PRI);
                    state_next.st = SIPM_ST_START_DLY;
                    state_next.dly_cnt = DLY_LOAD;
                end
            end
            SIPM_ST_START_DLY: begin
                if (state_reg.dly_cnt == '0) begin
                    state_next.st = SIPM_ST_RUN;
                end else begin
                    state_next.dly_cnt = state_reg.dly_cnt - 1'b1;
                end
            end
            default: begin
                state_next.st = SIPM_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.st <= SIPM_ST_RUN;
            state_reg.ctrl <= SIPM_CTRL_RESET;
            state_reg.act_src <= SIPM_SRC_PRI;
            state_reg.flag <= 1'b0;
            state_reg.dly_cnt <= '0;
            state_reg.rdy_s1 <= '0;
            state_reg.rdy_s2 <= '0;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= SIPM_ZERO_WORD;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock tree controls
    logic in_low;
    logic need_sel;
    assign in_low = (state_reg.st == SIPM_ST_SLEEP) | (state_reg.st == SIPM_ST_IDLE);
    assign need_sel = (state_reg.st != SIPM_ST_SLEEP);

    always_comb begin
        clk_ctl_out.cpu_clk_en = (state_reg.st == SIPM_ST_RUN);
        clk_ctl_out.periph_clk_en = (state_reg.st == SIPM_ST_RUN) | (state_reg.st == SIPM_ST_IDLE)
            | (state_reg.st == SIPM_ST_START_DLY);
        clk_ctl_out.sys_clk_sel = state_reg.act_src;
        // Selected oscillator stops only in Sleep
        clk_ctl_out.pri_osc_en = need_sel & ((state_reg.act_src == SIPM_SRC_PRI)
            | (state_reg.ctrl.system_clock_select == SIPM_SRC_PRI));
        clk_ctl_out.sec_osc_en = state_reg.ctrl.sec_osc_en | (need_sel & ((state_reg.act_src == SIPM_SRC_SEC)
            | (state_reg.ctrl.system_clock_select == SIPM_SRC_SEC)));
        clk_ctl_out.internal_rc_source_en = state_reg.ctrl.wdt_sel | (need_sel & (~in_low
            | state_reg.act_src == SIPM_SRC_INT)) | (state_reg.ctrl.system_clock_select[1] & need_sel);
    end
    assign primary_clock_status_flag_out = state_reg.flag;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_sleep_entry_flag: assert property (state_reg.st == SIPM_ST_RUN && sleep_instr_in && ce_in
        && !state_reg.ctrl.idle_on_sleep_enable |=> state_reg.st == SIPM_ST_SLEEP
        && !primary_clock_status_flag_out && !clk_ctl_out.pri_osc_en)
        else $error("sleep entry did not stop clocks or clear flag");
    a_keep_alive_osc: assert property (in_low |-> (!state_reg.ctrl.wdt_sel
        || clk_ctl_out.internal_rc_source_en) && (!state_reg.ctrl.sec_osc_en || clk_ctl_out.sec_osc_en))
        else $error("keep-alive oscillator stopped");
    a_wake_wait_gated: assert property (state_reg.st == SIPM_ST_WAKE_WAIT
        |-> !clk_ctl_out.cpu_clk_en && !clk_ctl_out.periph_clk_en)
        else $error("clocks running before source ready");
    a_two_speed_int: assert property (state_reg.st == SIPM_ST_WAKE_WAIT && ce_in
        && (state_reg.ctrl.two_speed_en || state_reg.ctrl.fscm_en)
        |=> state_reg.st == SIPM_ST_START_DLY && clk_ctl_out.sys_clk_sel == SIPM_SRC_INT)
        else $error("two-speed wake not on internal oscillator");
    a_primary_flag: assert property (state_reg.st == SIPM_ST_RUN && state_reg.act_src == SIPM_SRC_PRI
        && $past(state_reg.st) != SIPM_ST_RUN |-> primary_clock_status_flag_out)
        else $error("primary running without status flag");
    a_ctrl_hold: assert property (!wr_ctrl |=> $stable(state_reg.ctrl))
        else $error("control bits changed without a write");
    a_idle_entry: assert property (state_reg.st == SIPM_ST_RUN && sleep_instr_in && ce_in
        && state_reg.ctrl.idle_on_sleep_enable && state_reg.ctrl.system_clock_select == SIPM_SRC_PRI
        |=> state_reg.st == SIPM_ST_IDLE && !clk_ctl_out.cpu_clk_en && clk_ctl_out.periph_clk_en
        && primary_clock_status_flag_out == $past(primary_clock_status_flag_out))
        else $error("idle entry wrong");
    a_idle_exit_cause: assert property (state_reg.st == SIPM_ST_IDLE && !wake_ev
        |=> state_reg.st == SIPM_ST_IDLE)
        else $error("idle left without wake event");
    a_idle_wake_delay: assert property (state_reg.st == SIPM_ST_IDLE && wake_ev && ce_in
        |=> state_reg.st == SIPM_ST_START_DLY && state_reg.dly_cnt == DLY_LOAD
        && state_reg.act_src == $past(state_reg.act_src))
        else $error("idle wake did not load start delay");
    a_delay_release: assert property (state_reg.st == SIPM_ST_START_DLY && state_reg.dly_cnt == '0
        && ce_in |=> clk_ctl_out.cpu_clk_en)
        else $error("CPU not released after start delay");

    // Gating in sleep, idle, the start delay and run; idle refused with secondary stopped
    a_sleep_gated: assert property (state_reg.st == SIPM_ST_SLEEP |-> !clk_ctl_out.cpu_clk_en
        && !clk_ctl_out.periph_clk_en && !clk_ctl_out.pri_osc_en && !primary_clock_status_flag_out)
        else $error("clocks running in sleep");
    a_delay_gated: assert property (state_reg.st == SIPM_ST_START_DLY
        |-> !clk_ctl_out.cpu_clk_en && clk_ctl_out.periph_clk_en)
        else $error("CPU clocked during start delay");
    a_idle_cpu_stop: assert property (state_reg.st == SIPM_ST_IDLE
        |-> !clk_ctl_out.cpu_clk_en && clk_ctl_out.periph_clk_en)
        else $error("CPU clocked in idle");
    a_run_clocks: assert property (state_reg.st == SIPM_ST_RUN
        |-> clk_ctl_out.cpu_clk_en && clk_ctl_out.periph_clk_en)
        else $error("clocks stopped in run");
    a_sec_idle_refused: assert property (state_reg.st == SIPM_ST_RUN && sleep_instr_in && ce_in
        && state_reg.ctrl.idle_on_sleep_enable && state_reg.ctrl.system_clock_select == SIPM_SRC_SEC
        && !state_reg.ctrl.sec_osc_en |=> state_reg.st == SIPM_ST_RUN)
        else $error("idle entered with secondary stopped");

    // Source bookkeeping across idle, wake and run
    a_idle_keep_src: assert property (state_reg.st == SIPM_ST_IDLE
        |=> state_reg.act_src == $past(state_reg.act_src))
        else $error("source changed during idle");
    a_wake_on_select: assert property (state_reg.st == SIPM_ST_WAKE_WAIT && ce_in
        && !state_reg.ctrl.two_speed_en && !state_reg.ctrl.fscm_en && sel_rdy
        |=> state_reg.st == SIPM_ST_START_DLY && state_reg.act_src == $past(state_reg.ctrl.system_clock_select))
        else $error("wake not onto the selected source");
    a_primary_idle_mode_clock: assert property (state_reg.st == SIPM_ST_IDLE
        && state_reg.act_src == SIPM_SRC_PRI |-> clk_ctl_out.pri_osc_en && clk_ctl_out.periph_clk_en
        && clk_ctl_out.sys_clk_sel == SIPM_SRC_PRI)
        else $error("primary clock stopped in primary idle");
    a_primary_idle_mode_flag: assert property (state_reg.st == SIPM_ST_IDLE
        && state_reg.act_src == SIPM_SRC_PRI && primary_clock_status_flag_out |=> primary_clock_status_flag_out)
        else $error("status flag dropped in primary idle");
    a_sec_select: assert property (state_reg.st == SIPM_ST_RUN
        && state_reg.act_src == SIPM_SRC_SEC |-> clk_ctl_out.sys_clk_sel == SIPM_SRC_SEC && clk_ctl_out.sec_osc_en)
        else $error("secondary selected but not running");

    // Register port and clock enable
    a_bus_first_wait: assert property (bus_req && !state_reg.ack |-> avs_waitrequest_out)
        else $error("bus answered in its first cycle");
    a_bus_answer: assert property (bus_req && !state_reg.ack && ce_in |=> state_reg.ack)
        else $error("bus answer not prepared");
    a_ce_freeze: assert property (!ce_in |=> $stable(state_reg))
        else $error("state moved with clock enable low");

    c_sleep_wake: cover property (state_reg.st == SIPM_ST_WAKE_WAIT ##1 state_reg.st == SIPM_ST_START_DLY);
    c_idle_wake: cover property (state_reg.st == SIPM_ST_IDLE ##1 state_reg.st == SIPM_ST_START_DLY);
    c_primary_idle_mode_flag: cover property (state_reg.st == SIPM_ST_IDLE && primary_clock_status_flag_out);
    c_two_speed: cover property (state_reg.st == SIPM_ST_START_DLY && state_reg.act_src == SIPM_SRC_INT);
    c_int_idle: cover property (state_reg.st == SIPM_ST_IDLE && state_reg.act_src == SIPM_SRC_INT);

endmodule : sipm_power_manager

/* testbench/sipm_osc_model.sv */
// Oscillator model: each source reports ready some cycles after its enable rises.
// Assumes the clock controls of the power manager, same clock domain.
`timescale 1ns/1ps
module sipm_osc_model
    import sipm_pkg::*;
#(
    parameter int WARM = 6
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Enables in, ready out
    input wire sipm_clk_t clk_ctl_in,
    output sipm_rdy_t osc_rdy_out
);
    int cnt [3];
    logic [2:0] rdy;
    assign osc_rdy_out = rdy;
    // Ready drops on the next clock edge after a source is stopped
    always @(posedge core_clk_in or negedge rst_b_in) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_b_in || !clk_ctl_in[2-i]) begin
                cnt[i] <= 0;
            end else if (cnt[i] < WARM) begin
                cnt[i] <= cnt[i] + 1;
            end
            rdy[i] <= rst_b_in && clk_ctl_in[2-i] && cnt[i] >= WARM;
        end
    end
endmodule : sipm_osc_model

/* testbench/testbench.sv */
// Self-checking bench for the sleep and idle power manager.
// Assumes the oscillator model on the ready pins and Avalon-MM register access.
`timescale 1ns/1ps
module testbench;
    import sipm_pkg::*;
    localparam int DLY = 2;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ce_in = 1'b1;
    logic [1:0] avs_address_in = 2'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [2:0] wake = 3'h0;
    logic [3:0] oscillator_config_bits_in = 4'h5;
    sipm_rdy_t osc_rdy_in;
    sipm_clk_t clk_ctl_out;
    logic primary_clock_status_flag_out;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h81f6;
    int n;
    logic [31:0] rd;
    logic [6:0] ctl;
    always #2.5 core_clk_in = ~core_clk_in;
    sipm_power_manager #(.START_DELAY_CYCLES(DLY)) sipm_power_manager_inst (.core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in), .ce_in(ce_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .sleep_instr_in(wake[0]), .irq_wake_in(wake[1]),
        .watchdog_timer_timeout_in(wake[2]), .oscillator_config_bits_in(oscillator_config_bits_in),
        .osc_rdy_in(osc_rdy_in), .clk_ctl_out(clk_ctl_out),
        .primary_clock_status_flag_out(primary_clock_status_flag_out));
    sipm_osc_model sipm_osc_model_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .clk_ctl_in(clk_ctl_out), .osc_rdy_out(osc_rdy_in));
    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // Held request, released after the edge that sees waitrequest low
    task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= d;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        check(n < 40, 1);
    endtask : bus
    // Bit 0 sleep instruction, 1 interrupt, 2 watchdog time-out
    task pulse(input int k);
        @(posedge core_clk_in);
        wake <= 3'(1 << k);
        @(posedge core_clk_in);
        wake <= 3'h0;
    endtask : pulse
    task wait_run;
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (clk_ctl_out.cpu_clk_en !== 1'b1 && n < 80);
        check(n < 80, 1);
    endtask : wait_run
    task wait_src(input logic [1:0] s);
        for (int i = 0; i < 20; i++) begin
            bus(1'b0, SIPM_STATUS_ADDR, SIPM_ZERO_WORD);
            if (rd[6:5] === s) break;
        end
        check(rd[6:5], s);
    endtask : wait_src
    // Expected clock controls while asleep
    function automatic logic [1:0] sleep_ctl(input logic [6:0] c);
        return {c[SIPM_SEC_EN_BIT], c[SIPM_WDT_SEL_BIT]};
    endfunction : sleep_ctl
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        bus(1'b0, SIPM_CTRL_ADDR, SIPM_ZERO_WORD);
        check(rd, 32'h0000_0000);
        bus(1'b1, SIPM_STATUS_ADDR, 32'hFFFF_FFFF);
        bus(1'b1, 2'h3, 32'hFFFF_FFFF);
        bus(1'b0, 2'h3, SIPM_ZERO_WORD);
        check(rd, 32'h0000_0000);
        bus(1'b0, SIPM_STATUS_ADDR, SIPM_ZERO_WORD);
        check({rd[15:12], rd[7:0]}, {oscillator_config_bits_in, 8'h01});
        // Internal source, then back to primary to set the flag
        bus(1'b1, SIPM_CTRL_ADDR, 32'h0000_0004);
        wait_src(SIPM_SRC_INT);
        bus(1'b1, SIPM_CTRL_ADDR, SIPM_ZERO_WORD);
        wait_src(SIPM_SRC_PRI);
        check(primary_clock_status_flag_out, 1);
        // Primary idle: select already cleared, then idle enable set
        ctl = 7'h01;
        bus(1'b1, SIPM_CTRL_ADDR, 32'(ctl));
        pulse(0);
        @(negedge core_clk_in);
        check(clk_ctl_out[6:2], 5'b01001);
        check(primary_clock_status_flag_out, 1);
        repeat (5 + ($random(seed) & 15)) @(negedge core_clk_in);
        pulse(0);
        @(negedge core_clk_in);
        check(clk_ctl_out.cpu_clk_en, 0);
        pulse(1);
        wait_run();
        check(n, DLY + 1);
        check(primary_clock_status_flag_out, 1);
        bus(1'b0, SIPM_CTRL_ADDR, SIPM_ZERO_WORD);
        check(rd, 32'(ctl));
        // Sleep rounds with random keep-alive bits, wake alternating interrupt and watchdog
        for (int r = 0; r < 4; r++) begin
            ctl = 7'($random(seed)) & 7'h60;
            bus(1'b1, SIPM_CTRL_ADDR, 32'(ctl));
            pulse(0);
            @(negedge core_clk_in);
            check({clk_ctl_out[6:5], clk_ctl_out[2], primary_clock_status_flag_out}, 4'h0);
            check(clk_ctl_out[1:0], sleep_ctl(ctl));
            pulse(r[0] ? 2 : 1);
            @(negedge core_clk_in);
            check(clk_ctl_out[6:5], 2'b00);
            wait_run();
            check({clk_ctl_out.sys_clk_sel, primary_clock_status_flag_out}, 3'b001);
            bus(1'b0, SIPM_CTRL_ADDR, SIPM_ZERO_WORD);
            check(rd, 32'(ctl));
        end
        // Two-speed start-up runs from the internal block
        bus(1'b1, SIPM_CTRL_ADDR, 32'h0000_0008);
        pulse(0);
        pulse(1);
        repeat (2) @(negedge core_clk_in);
        check(clk_ctl_out.sys_clk_sel, SIPM_SRC_INT);
        wait_run();
        // Internal-oscillator idle resumes on the same source
        bus(1'b1, SIPM_CTRL_ADDR, 32'h0000_0005);
        wait_src(SIPM_SRC_INT);
        pulse(0);
        @(negedge core_clk_in);
        check({clk_ctl_out.cpu_clk_en, clk_ctl_out.sys_clk_sel}, {1'b0, SIPM_SRC_INT});
        pulse(2);
        wait_run();
        check(clk_ctl_out.sys_clk_sel, SIPM_SRC_INT);
        give_verdict();
    end
endmodule : testbench
